// >>> dff_regs.svh
`ifndef DFF_REGS_SVH
`define DFF_REGS_SVH

// taskfile register selects
`define DFF_SEL_DATA 3'h0
`define DFF_SEL_FEAT 3'h1
`define DFF_SEL_COUNT 3'h2
`define DFF_SEL_LOW 3'h3
`define DFF_SEL_MID 3'h4
`define DFF_SEL_HIGH 3'h5
`define DFF_SEL_DEVH 3'h6
`define DFF_SEL_CMD 3'h7

// opcodes and feature code
`define DFF_OP_FLUSH_EXT 8'hea
`define DFF_OP_FMT_TRACK 8'h50
`define DFF_OP_FMT_UNIT 8'hf7
`define DFF_OP_ERASE_PREP 8'hf3
`define DFF_FEAT_MERGE 8'h11

// status, error and device/head bit positions, reset status value
`define DFF_ST_BSY 7
`define DFF_ST_RDY 6
`define DFF_ST_DSC 4
`define DFF_ST_DRQ 3
`define DFF_ST_ERR 0
`define DFF_ER_CRC 7
`define DFF_ER_UNC 6
`define DFF_ER_IDN 4
`define DFF_ER_ABT 2
`define DFF_DH_LBA 6
`define DFF_STAT_RST 8'h50

// geometry
`define DFF_SPT 28'h000003f
`define DFF_HEADS 28'h0000010

// host register offsets
`define DFF_A_CTRL 8'h00
`define DFF_A_FEAT 8'h04
`define DFF_A_ADDR 8'h08
`define DFF_A_DEVH 8'h0c
`define DFF_A_STAT 8'h10
`define DFF_A_RES 8'h14
`define DFF_A_ISTAT 8'h18
`define DFF_A_IMASK 8'h1c
`define DFF_A_TMO 8'h20

// host field positions
`define DFF_CTRL_PREP 8
`define DFF_CTRL_RAWF 9
`define DFF_IRQ_DONE 0
`define DFF_IRQ_ERR 1
`define DFF_IRQ_TMO 2

// timing
`define DFF_CLK_HZ 64'd50000000
`define DFF_TMO_UNIT_S 64'd120

`endif

// >>> dff_pkg.sv
package dff_pkg;

	typedef logic [27:0] dff_blk_t;

	typedef enum logic [2:0] {
		DFF_D_IDLE = 3'h0,
		DFF_D_FLUSH = 3'h1,
		DFF_D_TRK = 3'h2,
		DFF_D_MERGE = 3'h3,
		DFF_D_UNIT = 3'h4
	} dff_dstate_e;

	typedef enum logic [1:0] {
		DFF_H_IDLE = 2'h0,
		DFF_H_SEND = 2'h1,
		DFF_H_WAIT = 2'h2
	} dff_hstate_e;

	typedef struct packed {
		dff_dstate_e st;
		logic [7:0] data;
		logic [7:0] feat;
		logic [7:0] cnt;
		logic [7:0] lo;
		logic [7:0] mid;
		logic [7:0] hi;
		logic [7:0] dh;
		logic [7:0] err;
		logic [7:0] stat;
		dff_blk_t cur;
		dff_blk_t last;
		logic lba_mode;
		logic armed;
		logic flush_req;
		logic merge_req;
		logic med_req;
	} dff_dev_s;

	typedef struct packed {
		dff_hstate_e st;
		logic [2:0] step;
		logic prep;
		logic rawf;
		logic auto_prep;
		logic [7:0] op;
		logic [7:0] feat;
		dff_blk_t addr;
		logic [7:0] dh;
		logic [15:0] tmo;
		logic [2:0] istat;
		logic [2:0] imask;
		logic [7:0] dstat;
		logic [7:0] derr;
		dff_blk_t res;
		logic [55:0] timer;
		logic we;
		logic [2:0] sel;
		logic [7:0] wdata;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} dff_host_s;

endpackage

// >>> dff_tf_if.sv
`timescale 1ns/100ps
interface dff_tf_if;
	logic we;
	logic [2:0] sel;
	logic [7:0] wdata;
	logic [7:0] error;
	logic [7:0] status;
	logic [7:0] address_low_byte;
	logic [7:0] address_middle_byte;
	logic [7:0] address_high_byte;
	logic [7:0] dev_head;
	logic [7:0] data_rd;

	modport dev (
		input we, sel, wdata,
		output error, status, address_low_byte, address_middle_byte,
			address_high_byte, dev_head, data_rd
	);

	modport host (
		output we, sel, wdata,
		input error, status, address_low_byte, address_middle_byte,
			address_high_byte, dev_head, data_rd
	);
endinterface

// >>> dff_device.sv
// Function
// [RL1] flush whole write cache first on EAh
// [RL2] report flush good only when cache empty
// [RL3] 50h formats exactly one logical track
// [RL4] zero every sector of that track
// [RL5] no read-back check after zero fill
// [RL6] block bits split over low, mid, high
// [RL7] head nibble carries block bits 24-27
// [RL8] chs mode: cylinder high/mid, head nibble
// [RL9] format whole track holding given block
// [RL10] return current block in same registers; code updates them in lba mode only
// [RL11] F7h merges lists, then fills sectors
// [RL12] new lists kept, old lists erased
// [RL13] unit format covers 0 to native top
// [RL14] unit format needs erase prepare before
// [RL15] unit format feature must be 11h
// [RL16] unit format has no data phase
// [RL17] host timeout from identify word 89
// [RL18] abort sets err and abort bits only
// [RL19] busy while running, then ready and dsc
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "dff_regs.svh"
module dff_device (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// taskfile link
	dff_tf_if.dev tf,
	// write cache
	input wire logic cache_dirty,
	output logic cache_flush_req,
	// defect and reassign lists
	output logic list_merge_req,
	input wire logic list_merge_ack,
	// media zero-fill writes
	output logic med_req,
	output dff_pkg::dff_blk_t med_lba,
	input wire logic med_ack,
	input wire dff_pkg::dff_blk_t native_top_block
);

	dff_pkg::dff_dev_s r;
	dff_pkg::dff_dev_s n;
	dff_pkg::dff_blk_t trk_lba;
	dff_pkg::dff_blk_t trk_chs;
	dff_pkg::dff_blk_t trk_base;
	dff_pkg::dff_blk_t trk_last;

	// final status byte
	function automatic logic [7:0] dff_stat(input logic fail);
		logic [7:0] s;
		s = 8'h00;
		s[`DFF_ST_RDY] = 1'b1;
		s[`DFF_ST_DSC] = 1'b1;
		s[`DFF_ST_ERR] = fail;
		return s;
	endfunction

	// [RL6] block number assembly
	// [RL7] top nibble from head field
	assign trk_lba = {r.dh[3:0], r.hi, r.mid, r.lo};
	// [RL8] cylinder and head to block
	assign trk_chs = (dff_pkg::dff_blk_t'({r.hi, r.mid}) * `DFF_HEADS
		+ dff_pkg::dff_blk_t'(r.dh[3:0])) * `DFF_SPT;
	// [RL9] round down to track start
	assign trk_base = r.dh[`DFF_DH_LBA] ?
		trk_lba - (trk_lba % `DFF_SPT) : trk_chs;
	assign trk_last = trk_base + `DFF_SPT - 28'h0000001;

	always_comb begin
		n = r;
		case (r.st)
		dff_pkg::DFF_D_IDLE: begin
			if (tf.we) begin
				case (tf.sel)
				`DFF_SEL_DATA: n.data = tf.wdata;
				`DFF_SEL_FEAT: n.feat = tf.wdata;
				`DFF_SEL_COUNT: n.cnt = tf.wdata;
				`DFF_SEL_LOW: n.lo = tf.wdata;
				`DFF_SEL_MID: n.mid = tf.wdata;
				`DFF_SEL_HIGH: n.hi = tf.wdata;
				`DFF_SEL_DEVH: n.dh = tf.wdata;
				`DFF_SEL_CMD: begin
					// [RL19] busy from acceptance
					n.stat = 8'h00;
					n.stat[`DFF_ST_BSY] = 1'b1;
					n.err = 8'h00;
					n.armed = 1'b0;
					case (tf.wdata)
					`DFF_OP_FLUSH_EXT: begin
						// [RL1] drain cache first
						n.flush_req = 1'b1;
						n.st = dff_pkg::DFF_D_FLUSH;
					end
					`DFF_OP_FMT_TRACK: begin
						if (trk_last > native_top_block) begin
							n.stat = dff_stat(1'b1);
							n.err[`DFF_ER_IDN] = 1'b1;
						end else begin
							// [RL3] one track range
							n.lba_mode = r.dh[`DFF_DH_LBA];
							n.cur = trk_base;
							n.last = trk_last;
							n.med_req = 1'b1;
							n.st = dff_pkg::DFF_D_TRK;
						end
					end
					`DFF_OP_FMT_UNIT: begin
						// [RL14] prepare must precede
						// [RL15] feature code check
						if (!r.armed || r.feat != `DFF_FEAT_MERGE) begin
							// [RL18] abort reporting
							n.stat = dff_stat(1'b1);
							n.err[`DFF_ER_ABT] = 1'b1;
						end else begin
							// [RL11] merge before fill
							n.merge_req = 1'b1;
							n.st = dff_pkg::DFF_D_MERGE;
						end
					end
					`DFF_OP_ERASE_PREP: begin
						// [RL14] arm for next command
						n.armed = 1'b1;
						n.stat = dff_stat(1'b0);
					end
					default: begin
						// [RL18] unknown opcode abort
						n.stat = dff_stat(1'b1);
						n.err[`DFF_ER_ABT] = 1'b1;
					end
					endcase
				end
				default: n.data = r.data;
				endcase
			end
		end
		dff_pkg::DFF_D_FLUSH: begin
			// [RL2] good status only once empty
			if (!cache_dirty) begin
				n.flush_req = 1'b0;
				n.stat = dff_stat(1'b0);
				n.st = dff_pkg::DFF_D_IDLE;
			end
		end
		dff_pkg::DFF_D_TRK: begin
			// [RL4] zero each sector in turn
			if (med_ack) begin
				if (r.cur == r.last) begin
					// [RL5] write only, no verify pass
					n.med_req = 1'b0;
					n.stat = dff_stat(1'b0);
					n.st = dff_pkg::DFF_D_IDLE;
					// [RL10] report current block, lba mode only
					if (r.lba_mode) begin
						n.lo = r.cur[7:0];
						n.mid = r.cur[15:8];
						n.hi = r.cur[23:16];
						n.dh = {r.dh[7:4], r.cur[27:24]};
					end
				end else begin
					n.cur = r.cur + 28'h0000001;
				end
			end
		end
		dff_pkg::DFF_D_MERGE: begin
			// [RL12] lists rebuilt and committed
			if (list_merge_ack) begin
				n.merge_req = 1'b0;
				// [RL13] full native range
				n.cur = 28'h0000000;
				n.last = native_top_block;
				n.med_req = 1'b1;
				n.st = dff_pkg::DFF_D_UNIT;
			end
		end
		dff_pkg::DFF_D_UNIT: begin
			if (med_ack) begin
				if (r.cur == r.last) begin
					n.med_req = 1'b0;
					// [RL16] completes without data request
					n.stat = dff_stat(1'b0);
					n.st = dff_pkg::DFF_D_IDLE;
				end else begin
					n.cur = r.cur + 28'h0000001;
				end
			end
		end
		default: begin
			n.st = dff_pkg::DFF_D_IDLE;
		end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.stat <= `DFF_STAT_RST;
		end else begin
			r <= n;
		end
	end

	assign tf.error = r.err;
	assign tf.status = r.stat;
	assign tf.address_low_byte = r.lo;
	assign tf.address_middle_byte = r.mid;
	assign tf.address_high_byte = r.hi;
	assign tf.dev_head = r.dh;
	assign tf.data_rd = r.data;
	assign cache_flush_req = r.flush_req;
	assign list_merge_req = r.merge_req;
	assign med_req = r.med_req;
	assign med_lba = r.cur;

endmodule // dff_device

// >>> dff_host.sv
`timescale 1ns/100ps
`include "dff_regs.svh"
module dff_host #(
	parameter logic [55:0] TMO_UNIT_CYC = 56'(`DFF_TMO_UNIT_S * `DFF_CLK_HZ)
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// taskfile link
	dff_tf_if.host tf
);

	dff_pkg::dff_host_s r;
	dff_pkg::dff_host_s n;
	logic [55:0] tmo_limit;

	function automatic logic dff_hit(input logic [7:0] a);
		return a <= `DFF_A_TMO && a[1:0] == 2'h0;
	endfunction

	assign tmo_limit = 56'(r.tmo) * TMO_UNIT_CYC;

	always_comb begin
		n = r;
		n.pready = psel && penable && !r.pready;
		if (psel && penable && !r.pready) begin
			n.pslverr = !dff_hit(paddr);
			case (paddr)
			`DFF_A_CTRL: n.prdata = {22'h0, r.rawf, r.auto_prep, r.op};
			`DFF_A_FEAT: n.prdata = {24'h0, r.feat};
			`DFF_A_ADDR: n.prdata = {4'h0, r.addr};
			`DFF_A_DEVH: n.prdata = {24'h0, r.dh};
			`DFF_A_STAT: n.prdata = {15'h0, r.st != dff_pkg::DFF_H_IDLE,
				r.derr, r.dstat};
			`DFF_A_RES: n.prdata = {4'h0, r.res};
			`DFF_A_ISTAT: n.prdata = {29'h0, r.istat};
			`DFF_A_IMASK: n.prdata = {29'h0, r.imask};
			`DFF_A_TMO: n.prdata = {16'h0, r.tmo};
			default: n.prdata = 32'h00000000;
			endcase
		end
		if (psel && penable && r.pready && pwrite) begin
			case (paddr)
			`DFF_A_CTRL: begin
				if (r.st == dff_pkg::DFF_H_IDLE) begin
					n.op = pwdata[7:0];
					n.auto_prep = pwdata[`DFF_CTRL_PREP];
					n.rawf = pwdata[`DFF_CTRL_RAWF];
					// [RL14] prepare sent right before unit format
					n.prep = pwdata[`DFF_CTRL_PREP] &&
						pwdata[7:0] == `DFF_OP_FMT_UNIT;
					n.step = 3'h0;
					n.st = dff_pkg::DFF_H_SEND;
				end
			end
			`DFF_A_FEAT: n.feat = pwdata[7:0];
			`DFF_A_ADDR: n.addr = pwdata[27:0];
			`DFF_A_DEVH: n.dh = pwdata[7:0];
			`DFF_A_ISTAT: n.istat = r.istat & ~pwdata[2:0];
			`DFF_A_IMASK: n.imask = pwdata[2:0];
			`DFF_A_TMO: n.tmo = pwdata[15:0];
			default: n.tmo = n.tmo;
			endcase
		end
		n.we = 1'b0;
		case (r.st)
		dff_pkg::DFF_H_IDLE: n.step = 3'h0;
		dff_pkg::DFF_H_SEND: begin
			n.we = 1'b1;
			n.step = r.step + 3'h1;
			case (r.step)
			3'h0: begin
				n.sel = `DFF_SEL_FEAT;
				// [RL15] merge code for unit format
				n.wdata = (r.op == `DFF_OP_FMT_UNIT && !r.rawf) ?
					`DFF_FEAT_MERGE : r.feat;
			end
			3'h1: begin
				n.sel = `DFF_SEL_COUNT;
				n.wdata = 8'h00;
			end
			// [RL6] block bytes to address registers
			3'h2: begin
				n.sel = `DFF_SEL_LOW;
				n.wdata = r.addr[7:0];
			end
			3'h3: begin
				n.sel = `DFF_SEL_MID;
				n.wdata = r.addr[15:8];
			end
			3'h4: begin
				n.sel = `DFF_SEL_HIGH;
				n.wdata = r.addr[23:16];
			end
			3'h5: begin
				// [RL7] top nibble or head number
				// [RL8] cylinder in high/mid, head here
				n.sel = `DFF_SEL_DEVH;
				n.wdata = {r.dh[7:4], r.addr[27:24]};
			end
			default: begin
				n.sel = `DFF_SEL_CMD;
				n.wdata = r.prep ? `DFF_OP_ERASE_PREP : r.op;
				n.timer = 56'h0;
				n.st = dff_pkg::DFF_H_WAIT;
			end
			endcase
		end
		dff_pkg::DFF_H_WAIT: begin
			n.timer = r.timer + 56'h1;
			if (!r.we && !tf.status[`DFF_ST_BSY]) begin
				if (r.prep && !tf.status[`DFF_ST_ERR]) begin
					n.prep = 1'b0;
					n.step = 3'h0;
					n.st = dff_pkg::DFF_H_SEND;
				end else begin
					n.dstat = tf.status;
					n.derr = tf.error;
					n.res = {tf.dev_head[3:0], tf.address_high_byte,
						tf.address_middle_byte, tf.address_low_byte};
					n.istat[`DFF_IRQ_DONE] = 1'b1;
					n.istat[`DFF_IRQ_ERR] = n.istat[`DFF_IRQ_ERR] |
						tf.status[`DFF_ST_ERR];
					n.st = dff_pkg::DFF_H_IDLE;
				end
			end else if (r.tmo != 16'h0 && r.timer >= tmo_limit) begin
				// [RL17] timeout scaled by word 89
				n.istat[`DFF_IRQ_TMO] = 1'b1;
				n.st = dff_pkg::DFF_H_IDLE;
			end
		end
		default: n.st = dff_pkg::DFF_H_IDLE;
		endcase
		n.irq = |(n.istat & n.imask);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign irq = r.irq;
	assign tf.we = r.we;
	assign tf.sel = r.sel;
	assign tf.wdata = r.wdata;

endmodule // dff_host

// >>> dff_chk_sva.sv
`timescale 1ns/100ps
module dff_chk_sva (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// taskfile link
	input wire logic we,
	input wire logic [2:0] sel,
	input wire logic [7:0] wdata,
	input wire logic [7:0] error,
	input wire logic [7:0] status
);
	logic cmd;
	logic armed_r;
	logic [7:0] feat_r;
	assign cmd = we && sel == 3'h7 && !status[7];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			armed_r <= 1'b0;
			feat_r <= 8'h00;
		end else begin
			if (cmd)
				armed_r <= wdata == 8'hf3;
			if (we && sel == 3'h1 && !status[7])
				feat_r <= wdata;
		end
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	flush_busy_a: assert property (
		cmd && wdata == 8'hea |=> status == 8'h80) else $error("flush idle");
	track_start_a: assert property (
		cmd && wdata == 8'h50 |=> status[7] ||
		(status == 8'h51 && error == 8'h10)) else $error("track start");
	prep_ok_a: assert property (
		cmd && wdata == 8'hf3 |=> status == 8'h50) else $error("prep status");
	unit_abort_a: assert property (
		cmd && wdata == 8'hf7 && (!armed_r || feat_r != 8'h11)
		|=> status == 8'h51 && error == 8'h04) else $error("unit no abort");
	unit_start_a: assert property (
		cmd && wdata == 8'hf7 && armed_r && feat_r == 8'h11 |=> status[7])
		else $error("unit not busy");
	bad_op_a: assert property (
		cmd && !(wdata inside {8'hea, 8'h50, 8'hf7, 8'hf3})
		|=> status == 8'h51 && error == 8'h04) else $error("op not aborted");
	err_clean_a: assert property (
		status[0] |-> error[7:6] == 2'b00) else $error("crc or unc set");
	no_drq_a: assert property (!status[3]) else $error("drq set");
	done_flags_a: assert property (
		$fell(status[7]) |-> status[6] && status[4]) else $error("done flags");
endmodule // dff_chk_sva

// >>> tb.sv
`timescale 1ns/100ps
module tb;
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cache_dirty, cache_flush_req, list_merge_req, mseen;
	logic med_req, med_ack = 0, list_merge_ack = 0;
	dff_pkg::dff_blk_t med_lba, exp_lba, top;
	integer fails = 0, total_checks = 0, seed = 84, n, a, base;
	dff_tf_if tf();
	dff_host #(.TMO_UNIT_CYC(56'd50)) dff_host_inst (.core_clk(core_clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .tf(tf.host));
	dff_device dff_device_inst (.core_clk(core_clk), .rst(rst),
		.tf(tf.dev), .cache_dirty(cache_dirty),
		.cache_flush_req(cache_flush_req), .list_merge_req(list_merge_req),
		.list_merge_ack(list_merge_ack), .med_req(med_req),
		.med_lba(med_lba), .med_ack(med_ack),
		.native_top_block(top));
	dff_chk_sva dff_chk_sva_inst (.core_clk(core_clk), .rst(rst),
		.we(tf.we), .sel(tf.sel), .wdata(tf.wdata), .error(tf.error),
		.status(tf.status));
	initial begin
		core_clk = 0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic fin(input logic [15:0] se, input integer en);
		while (irq !== 1'b1) @(posedge core_clk);
		apb(0, 8'h10, 0);
		chk(rd, {16'h0, se});
		chk(n, en);
		apb(0, 8'h18, 0);
		chk(rd, se[0] ? 3 : 1);
		apb(1, 8'h18, 7);
		apb(0, 8'h18, 0);
		chk(rd | irq, 0);
	endtask
	always @(posedge core_clk) begin
		med_ack <= 1'($random(seed));
		list_merge_ack <= list_merge_req & 1'($random(seed));
		if (list_merge_req)
			mseen = 1;
		if (med_req && med_ack) begin
			chk({4'h0, med_lba}, {4'h0, exp_lba});
			chk(list_merge_req, 0);
			exp_lba = exp_lba + 1;
			n = n + 1;
		end
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		fails++;
		test_done;
	end
	initial begin
		rst = 1;
		{psel, penable, pwrite, paddr, pwdata, cache_dirty, mseen} = 0;
		top = 28'h00003ff;
		n = 0;
		repeat (10) @(posedge core_clk);
		rst <= 0;
		apb(0, 8'h40, 0);
		chk({rd[30:0], err}, 1);
		apb(1, 8'h00, 8'h12);
		repeat (40) @(posedge core_clk);
		chk(irq, 0);
		apb(1, 8'h1c, 7);
		fin(16'h0451, 0);
		cache_dirty <= 1;
		apb(1, 8'h00, 8'hea);
		repeat (30) @(posedge core_clk);
		chk({irq, cache_flush_req}, 1);
		cache_dirty <= 0;
		fin(16'h0050, 0);
		apb(1, 8'h20, 1);
		cache_dirty <= 1;
		apb(1, 8'h00, 8'hea);
		while (irq !== 1'b1) @(posedge core_clk);
		apb(0, 8'h18, 0);
		chk(rd, 4);
		cache_dirty <= 0;
		apb(1, 8'h18, 7);
		apb(1, 8'h20, 0);
		apb(1, 8'h0c, 8'h40);
		repeat (2) begin
			a = {$random(seed)} % 900;
			base = a / 63 * 63;
			exp_lba = 28'(base);
			n = 0;
			apb(1, 8'h08, a);
			apb(1, 8'h00, 8'h50);
			fin(16'h0050, 63);
			apb(0, 8'h14, 0);
			chk(rd, base + 62);
		end
		apb(1, 8'h0c, 0);
		apb(1, 8'h08, 32'h05000000);
		exp_lba = 28'd315;
		n = 0;
		apb(1, 8'h00, 8'h50);
		fin(16'h0050, 63);
		apb(1, 8'h08, 32'h03000100);
		n = 0;
		apb(1, 8'h00, 8'h50);
		fin(16'h1051, 0);
		apb(1, 8'h04, 8'h22);
		apb(1, 8'h00, 32'h3f7);
		fin(16'h0451, 0);
		apb(1, 8'h04, 8'h11);
		apb(1, 8'h00, 32'h2f7);
		fin(16'h0451, 0);
		mseen = 0;
		exp_lba = 0;
		top <= 28'(700 + {$random(seed)} % 300);
		apb(1, 8'h00, 32'h1f7);
		fin(16'h0050, top + 1);
		chk(mseen, 1);
		test_done;
	end
endmodule // tb
